/* hdl/adc_result_defs.vh */
// Constants for the converter result formatting and clock control block.
// What this block does
// - Left-justified mode puts result bits 9..2 in the high result register.
// - Right-justified mode puts result bits 9..8 in high bits 1..0, other bits read zero.
// - Left-justified mode puts result bits 1..0 in low bits 7..6, other bits read zero.
// - Right-justified mode puts result bits 7..0 in the low result register.
// - Truncation mode puts result bits 9..2 in the low register with no read interlock.
// - In justified modes a high read freezes the low register until it is read.
// - Each finished conversion updates the result registers unless they are frozen.
// - The prescale field divides the input clock by 1, 2, 4, 8, or 16 when bit 2 is set.
// - Source select 1 picks the bus clock, 0 the crystal clock, and reset clears it.
// - The 2-bit format field picks truncation, right, left or left signed; reset is right.
// - Left signed mode is left-justified with the top result bit inverted.
// - With interrupts disabled, a result register read clears the complete flag.
`ifndef ADC_RESULT_DEFS_VH
`define ADC_RESULT_DEFS_VH

// Register byte addresses on the Avalon-MM slave.
`define ADDR_RESULT_HIGH      4'h0
`define ADDR_RESULT_LOW       4'h4
`define ADDR_CLOCK_FORMAT     4'h8
`define ADDR_STATUS           4'hC

// Field positions in converter_clock_and_format.
`define PRESCALE_MSB          7
`define PRESCALE_LSB          5
`define SOURCE_BIT            4
`define MODE_MSB              3
`define MODE_LSB              2

// Reset value: prescale /1, crystal source, right-justified.
`define CLOCK_FORMAT_RESET    8'h04

// Justification encodings.
`define MODE_TRUNCATE         2'h0
`define MODE_RIGHT            2'h1
`define MODE_LEFT             2'h2
`define MODE_LEFT_SIGNED      2'h3

// Status register fields.
`define STATUS_COMPLETE_BIT   0
`define STATUS_FROZEN_BIT     1

`endif

/* hdl/adc_result_and_clock_control.v */
// Result formatting, read interlock and converter clock prescaler with an Avalon-MM slave.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "adc_result_defs.vh"

module adc_result_and_clock_control (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output wire        avs_waitrequest,
    output wire [31:0] avs_readdata,
    input  wire        crystal_derived_clock,
    input  wire        conv_done,
    input  wire [9:0]  conv_result,
    input  wire        interrupts_enabled,
    output wire        converter_clk_en,
    output wire        conversion_complete_flag
);

    reg  [7:0]  result_high_byte_reg;
    reg  [7:0]  result_low_byte_reg;
    reg  [7:0]  clock_format_reg;
    reg         complete_reg;
    reg         frozen_reg;
    reg         ack_reg;
    reg  [31:0] readdata_reg;
    reg         xtal_meta_reg;
    reg         xtal_sync_reg;
    reg         xtal_last_reg;
    reg  [3:0]  prescale_count_reg;
    reg  [3:0]  prescale_count_next;
    reg         clk_en_reg;
    reg  [7:0]  high_next;
    reg  [7:0]  low_next;

    wire [2:0]  prescale_select;
    wire        clock_source_select;
    wire [1:0]  justification_select;
    wire        access_done;
    wire        read_high;
    wire        read_low;
    wire        write_clock;
    wire        source_tick;
    wire        take_result;
    wire        result_read;

    assign prescale_select      = clock_format_reg[`PRESCALE_MSB:`PRESCALE_LSB];
    assign clock_source_select  = clock_format_reg[`SOURCE_BIT];
    assign justification_select = clock_format_reg[`MODE_MSB:`MODE_LSB];

    // Terminal count mask for the prescaler; any value with bit 2 set divides by 16.
    function [3:0] divide_mask;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    divide_mask = 4'h0;
                3'h1:    divide_mask = 4'h1;
                3'h2:    divide_mask = 4'h3;
                3'h3:    divide_mask = 4'h7;
                default: divide_mask = 4'hF;
            endcase
        end
    endfunction

    // Every access costs one wait state; the answer and its side effects land together.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign access_done     = (avs_read | avs_write) & ack_reg;
    assign read_high       = access_done & avs_read & (avs_address == `ADDR_RESULT_HIGH);
    assign read_low        = access_done & avs_read & (avs_address == `ADDR_RESULT_LOW);
    assign write_clock     = access_done & avs_write & (avs_address == `ADDR_CLOCK_FORMAT);
    assign result_read     = read_high | read_low;
    assign avs_readdata    = readdata_reg;

    // Acknowledge pulses one cycle after a request is seen, then drops so requests can follow.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    // Read data is captured on the first cycle so it is stable when waitrequest drops.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            case (avs_address)
                `ADDR_RESULT_HIGH:  readdata_reg <= {24'h00_0000, result_high_byte_reg};
                `ADDR_RESULT_LOW:   readdata_reg <= {24'h00_0000, result_low_byte_reg};
                `ADDR_CLOCK_FORMAT: readdata_reg <= {24'h00_0000, clock_format_reg};
                `ADDR_STATUS:       readdata_reg <= {30'h0000_0000, frozen_reg, complete_reg};
                default:            readdata_reg <= 32'h0000_0000; // Unmapped reads zero.
            endcase
        end
    end

    // Control register; the low two bits are reserved and read as zero.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clock_format_reg <= `CLOCK_FORMAT_RESET;
        end else if (write_clock) begin
            clock_format_reg <= {avs_writedata[7:2], 2'b00};
        end
    end

    // Format the incoming result; mode is sampled only when a conversion finishes.
    always @* begin
        high_next = 8'h00;
        low_next  = 8'h00;
        case (justification_select)
            `MODE_TRUNCATE: begin
                low_next = conv_result[9:2];
            end
            `MODE_RIGHT: begin
                high_next = {6'h00, conv_result[9:8]};
                low_next  = conv_result[7:0];
            end
            `MODE_LEFT: begin
                high_next = conv_result[9:2];
                low_next  = {conv_result[1:0], 6'h00};
            end
            default: begin
                high_next = {~conv_result[9], conv_result[8:2]};
                low_next  = {conv_result[1:0], 6'h00};
            end
        endcase
    end

    // A frozen pair drops new results; truncation mode never honours the freeze.
    assign take_result = conv_done &
                         (~frozen_reg | (justification_select == `MODE_TRUNCATE));

    // Result registers hold what was latched, so later mode writes cannot disturb them.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            result_high_byte_reg <= 8'h00;
            result_low_byte_reg  <= 8'h00;
        end else if (take_result) begin
            result_high_byte_reg <= high_next;
            result_low_byte_reg  <= low_next;
        end
    end

    // High read arms the interlock in justified modes; low read releases it.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frozen_reg <= 1'b0;
        end else if (read_low) begin
            frozen_reg <= 1'b0;
        end else if (read_high && justification_select != `MODE_TRUNCATE) begin
            frozen_reg <= 1'b1;
        end
    end

    // Completion flag; a result taken into the registers wins over a clearing read in the same cycle.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            complete_reg <= 1'b0;
        end else if (take_result) begin
            complete_reg <= 1'b1;
        end else if (result_read && !interrupts_enabled) begin
            complete_reg <= 1'b0;
        end
    end

    assign conversion_complete_flag = complete_reg;

    // The crystal clock is asynchronous, so it is synchronised before edge detection.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xtal_meta_reg <= 1'b0;
            xtal_sync_reg <= 1'b0;
            xtal_last_reg <= 1'b0;
        end else begin
            xtal_meta_reg <= crystal_derived_clock;
            xtal_sync_reg <= xtal_meta_reg;
            xtal_last_reg <= xtal_sync_reg;
        end
    end

    // Source tick: every bus cycle, or each crystal rising edge; the crystal must run well
    // below half the bus rate for edges to be seen.
    assign source_tick = clock_source_select ? 1'b1 : (xtal_sync_reg & ~xtal_last_reg);

    // Prescaler counter restarts on a clock-setting write so the new ratio starts cleanly.
    always @* begin
        prescale_count_next = prescale_count_reg;
        if (write_clock) begin
            prescale_count_next = 4'h0;
        end else if (source_tick) begin
            if ((prescale_count_reg & divide_mask(prescale_select)) ==
                divide_mask(prescale_select)) begin
                prescale_count_next = 4'h0;
            end else begin
                prescale_count_next = prescale_count_reg + 4'h1;
            end
        end
    end

    // The converter clock leaves as a one-cycle enable pulse on each terminal count.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prescale_count_reg <= 4'h0;
            clk_en_reg         <= 1'b0;
        end else begin
            prescale_count_reg <= prescale_count_next;
            clk_en_reg         <= ~write_clock & source_tick &
                                  ((prescale_count_reg & divide_mask(prescale_select)) ==
                                   divide_mask(prescale_select));
        end
    end

    assign converter_clk_en = clk_en_reg;

endmodule // adc_result_and_clock_control

/* bench/adc_result_and_clock_control_properties.sv */
// Port-level assertions for the converter result and clock control block.
`timescale 1ns/1ps
`include "adc_result_defs.vh"

module adc_result_and_clock_control_properties (
    input wire        clk_sys,
    input wire        reset_n,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    input wire [31:0] avs_readdata,
    input wire        crystal_derived_clock,
    input wire        conv_done,
    input wire [9:0]  conv_result,
    input wire        interrupts_enabled,
    input wire        converter_clk_en,
    input wire        conversion_complete_flag
);
    reg  [7:0] ctl_reg;
    reg  [1:0] quiet_reg;
    wire       ctl_wr = avs_write && !avs_waitrequest && avs_address == `ADDR_CLOCK_FORMAT;
    wire       res_rd = avs_read && !avs_waitrequest &&
                        (avs_address == `ADDR_RESULT_HIGH || avs_address == `ADDR_RESULT_LOW);

    // Shadow of the control register; the divider restarts on a write, so wait out that edge.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctl_reg <= `CLOCK_FORMAT_RESET;
            quiet_reg <= 2'h0;
        end else begin
            if (ctl_wr)
                ctl_reg <= avs_writedata[7:0];
            quiet_reg <= ctl_wr ? 2'h0 : (quiet_reg == 2'h3 ? 2'h3 : quiet_reg + 2'h1);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    idle_wait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest without request");
    upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    bus_div1_a: assert property (quiet_reg == 2'h3 && ctl_reg[7:4] == 4'h1 |-> converter_clk_en)
        else $error("bus clock divide by one missed a pulse");
    pulse_single_a: assert property (converter_clk_en && ctl_reg[4] && ctl_reg[7:5] != 3'h0 |=> !converter_clk_en)
        else $error("divided enable longer than one cycle");
    flag_set_a: assert property (conv_done && ctl_reg[3:2] == `MODE_TRUNCATE |=> conversion_complete_flag)
        else $error("complete flag not set");
    flag_clear_a: assert property (res_rd && !interrupts_enabled && !conv_done |=> !conversion_complete_flag)
        else $error("result read did not clear flag");
    flag_hold_a: assert property (conversion_complete_flag && interrupts_enabled |=> conversion_complete_flag)
        else $error("flag cleared with interrupts enabled");
    flag_cause_a: assert property (!conversion_complete_flag && !conv_done |=> !conversion_complete_flag)
        else $error("flag set without a conversion");
endmodule // adc_result_and_clock_control_properties

bind adc_result_and_clock_control adc_result_and_clock_control_properties chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .crystal_derived_clock(crystal_derived_clock),
    .conv_done(conv_done), .conv_result(conv_result), .interrupts_enabled(interrupts_enabled),
    .converter_clk_en(converter_clk_en), .conversion_complete_flag(conversion_complete_flag));

/* bench/tb_adc_result_and_clock_control.sv */
// Self-checking testbench for the converter result and clock control block.
`timescale 1ns/1ps
`include "adc_result_defs.vh"

module tb_adc_result_and_clock_control;
    reg         clk_sys = 1'b0;
    reg         reset_n = 1'b0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0000_0000;
    reg  [2:0]  xtal_div = 3'h0;
    reg         conv_done = 1'b0;
    reg  [9:0]  conv_result = 10'h000;
    reg         interrupts_enabled = 1'b0;
    wire        avs_waitrequest;
    wire [31:0] avs_readdata;
    wire        converter_clk_en;
    wire        conversion_complete_flag;
    integer     n_errors = 0;
    integer     compares = 0;
    integer     cycles = 0;
    reg  [31:0] rd;

    adc_result_and_clock_control uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .crystal_derived_clock(xtal_div[2]), .conv_done(conv_done),
        .conv_result(conv_result), .interrupts_enabled(interrupts_enabled),
        .converter_clk_en(converter_clk_en), .conversion_complete_flag(conversion_complete_flag));

    // Bus clock at 25 MHz.
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    // Crystal pin runs at one eighth of the bus clock, above 1 MHz, so it may feed the divider
    // directly; the cycle ceiling cuts a hang short.
    always @(posedge clk_sys) begin
        xtal_div <= xtal_div + 3'h1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            stop_test;
        end
    end

    task check(input [31:0] got, input [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon cycle; request held until waitrequest is seen low at a rising edge.
    task bus(input wr, input [3:0] a, input [31:0] d, output [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // Let one edge pass so a following call never re-raises a strobe in the same step.
        @(posedge clk_sys);
    endtask

    task conv(input [9:0] r);
        conv_result <= r;
        conv_done <= 1'b1;
        @(posedge clk_sys);
        conv_done <= 1'b0;
    endtask

    // Expected {high, low} bytes for a format code.
    function [15:0] fmt(input [1:0] m, input [9:0] r);
        case (m)
            2'h0: fmt = {8'h00, r[9:2]};
            2'h1: fmt = {6'h00, r};
            2'h2: fmt = {r[9:2], r[1:0], 6'h00};
            default: fmt = {~r[9], r[8:2], r[1:0], 6'h00};
        endcase
    endfunction

    task test_reset;
        bus(1'b0, `ADDR_CLOCK_FORMAT, 32'h0000_0000, rd);
        check(rd, 32'h0000_0004);
        bus(1'b1, 4'h1, 32'h0000_00FF, rd);
        bus(1'b0, 4'h1, 32'h0000_0000, rd);
        check(rd, 32'h0000_0000);
        bus(1'b0, `ADDR_CLOCK_FORMAT, 32'h0000_0000, rd);
        check(rd, 32'h0000_0004);
    endtask

    task test_formats;
        integer i;
        reg [15:0] e;
        for (i = 0; i < 4; i = i + 1) begin
            e = fmt(i[1:0], 10'h2D5);
            bus(1'b1, `ADDR_CLOCK_FORMAT, {24'h00_0000, 4'h1, i[1:0], 2'h0}, rd);
            conv(10'h2D5);
            bus(1'b0, `ADDR_RESULT_HIGH, 32'h0000_0000, rd);
            check(rd, {24'h00_0000, e[15:8]});
            bus(1'b0, `ADDR_RESULT_LOW, 32'h0000_0000, rd);
            check(rd, {24'h00_0000, e[7:0]});
            bus(1'b0, `ADDR_STATUS, 32'h0000_0000, rd);
            check(rd, 32'h0000_0000);
        end
    endtask

    task test_interlock;
        bus(1'b1, `ADDR_CLOCK_FORMAT, 32'h0000_0014, rd);
        conv(10'h3A7);
        bus(1'b1, `ADDR_CLOCK_FORMAT, 32'h0000_0018, rd);
        bus(1'b0, `ADDR_RESULT_HIGH, 32'h0000_0000, rd);
        check(rd, 32'h0000_0003);
        conv(10'h0C1);
        bus(1'b0, `ADDR_STATUS, 32'h0000_0000, rd);
        check(rd, 32'h0000_0002);
        bus(1'b0, `ADDR_RESULT_LOW, 32'h0000_0000, rd);
        check(rd, 32'h0000_00A7);
        conv(10'h0C1);
        bus(1'b0, `ADDR_RESULT_HIGH, 32'h0000_0000, rd);
        check(rd, 32'h0000_0030);
        bus(1'b1, `ADDR_CLOCK_FORMAT, 32'h0000_0010, rd);
        bus(1'b0, `ADDR_RESULT_HIGH, 32'h0000_0000, rd);
        interrupts_enabled <= 1'b1;
        conv(10'h155);
        bus(1'b0, `ADDR_RESULT_LOW, 32'h0000_0000, rd);
        check(rd, 32'h0000_0055);
        bus(1'b0, `ADDR_STATUS, 32'h0000_0000, rd);
        check(rd, 32'h0000_0001);
        check({31'h0000_0000, conversion_complete_flag}, 32'h0000_0001);
        interrupts_enabled <= 1'b0;
    endtask

    // Counts enable pulses over 64 cycles for every prescale code, then the crystal source.
    task test_clock;
        integer p;
        integer n;
        for (p = 0; p < 9; p = p + 1) begin
            bus(1'b1, `ADDR_CLOCK_FORMAT, {24'h00_0000, p[2:0], p < 8, 4'h4}, rd);
            repeat (4) @(posedge clk_sys);
            n = 0;
            repeat (64) begin
                @(posedge clk_sys);
                n = n + converter_clk_en;
            end
            check(n, p == 8 ? 8 : 64 >> (p > 3 ? 4 : p));
        end
        // Crystal source divided by four sits inside the recommended converter clock band.
        bus(1'b1, `ADDR_CLOCK_FORMAT, 32'h0000_0044, rd);
        repeat (4) @(posedge clk_sys);
        n = 0;
        repeat (64) begin
            @(posedge clk_sys);
            n = n + converter_clk_en;
        end
        check(n, 32'h0000_0002);
    endtask

    task stop_test;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset for three cycles, then the scenarios in turn.
    initial begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        test_reset;
        $display("test_reset done");
        test_formats;
        $display("test_formats done");
        test_interlock;
        $display("test_interlock done");
        test_clock;
        $display("test_clock done");
        stop_test;
    end
endmodule // tb_adc_result_and_clock_control
